// ### core/ccs_charge_sequencer.sv
// Purpose: charge cycle sequencer with AXI4-Lite status and period registers
// Assumes: analog flags synchronous to clk_i, sw_cycle_i pulses once per switch cycle
// Notes: status outputs are open drain, "on" means the pin is pulled low
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
module ccs_charge_sequencer #(
  parameter int unsigned         TW          = ccs_pkg::TIMER_W,
  parameter int unsigned         PRESCALE    = ccs_pkg::PRESCALE_DEFAULT,
  parameter logic [TW-1:0]       EOC_DEFAULT = TW'(ccs_pkg::EOC_DEFAULT)
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  ccs_pkg::ccs_level_type algorithm_strap_a_i,
  input  ccs_pkg::ccs_level_type algorithm_strap_b_i,
  input  ccs_pkg::ccs_lockout_type supply_lockout_i,
  input  wire logic              cycle_timer_input_i,
  input  wire logic              cv_mode_i,
  input  wire logic              current_tenth_i,
  input  wire logic              fb_below_lb_i,
  input  wire logic              fb_below_rechg_i,
  input  wire logic              thermistor_disable_i,
  input  wire logic              over_temp_i,
  input  wire logic              cooled_i,
  input  wire logic              ocp_trip_i,
  input  wire logic              sw_cycle_i,
  output logic                   charge_indicator_a_o,
  output logic                   charge_indicator_a_oe_o,
  output logic                   charge_indicator_b_o,
  output logic                   charge_indicator_b_oe_o,
  output logic                   charge_pump_en_o,
  output logic                   switching_en_o,
  output logic                   input_isolation_gate_pulldown_o,
  output ccs_pkg::ccs_target_type target_o,
  output logic [8:0]             target_step_mv_o,
  output logic                   wide_spread_o,
  output logic                   recharge_deep_o,
  output logic                   current_fifth_o,
  output logic                   ntc_comp_en_o,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [3:0]        s_axi_awaddr_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [3:0]        s_axi_araddr_i,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o
);
  ccs_pkg::ccs_state_type state;
  ccs_pkg::ccs_state_type next_state;
  ccs_pkg::ccs_cfg_type   cfg;
  ccs_pkg::ccs_cfg_type   strap_cfg;
  logic [ccs_pkg::PRESCALE_W-1:0] pre;
  logic [TW-1:0] period;
  logic [TW-1:0] cyc_timer;
  logic [TW-1:0] lb_timer;
  logic          tick;
  logic          lock_ok;
  logic          charging;
  logic          lb_q;
  logic          lb_fall;
  logic          timer_full;
  logic          eq_hit;
  logic          eq_done;
  logic          therm;
  logic          ocp_hold;
  logic          next_a_on;
  logic          next_b_on;
  logic          wr_go;
  logic          rd_go;

  ccs_strap_decode u_decode (
    .algorithm_strap_a_i (algorithm_strap_a_i),
    .algorithm_strap_b_i (algorithm_strap_b_i),
    .cfg_o               (strap_cfg)
  );

  ccs_hold_counter #(.W(3)) u_ocp_hold (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (ocp_trip_i),
    .load_val_i (ccs_pkg::OCP_HOLD_CYCLES),
    .dec_i      (sw_cycle_i),
    .busy_o     (ocp_hold)
  );

  assign lock_ok  = &supply_lockout_i;
  assign charging = (state == ccs_pkg::ST_CC) || (state == ccs_pkg::ST_ABS) ||
                    (state == ccs_pkg::ST_EQ) || (state == ccs_pkg::ST_FLT);
  assign lb_fall  = fb_below_lb_i && !lb_q;

  // timebase: prescaler then exact binary fractions of the period
  assign tick       = (pre == ccs_pkg::PRESCALE_W'(PRESCALE - 1));
  assign timer_full = (cyc_timer >= period);
  assign eq_hit     = cyc_timer >= (cfg.eq_quarter ? (period >> ccs_pkg::EQ_SHIFT_QUARTER)
                                                   : (period >> ccs_pkg::EQ_SHIFT_EIGHTH));

  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
      pre <= '0;
    else
      pre <= pre + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lb_q <= 1'b0;
    else
      lb_q <= fb_below_lb_i;
  end

  // main timer: cleared on entry to absorb or equalize, counts only in phase
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cyc_timer <= '0;
    else if ((next_state == ccs_pkg::ST_ABS && state == ccs_pkg::ST_CC) ||
             (next_state == ccs_pkg::ST_EQ && state != ccs_pkg::ST_EQ))
      cyc_timer <= '0;
    else if (tick && cycle_timer_input_i && !timer_full &&
             ((state == ccs_pkg::ST_ABS && cv_mode_i) || state == ccs_pkg::ST_EQ))
      cyc_timer <= cyc_timer + 1'b1;
  end

  // low-battery timer runs only while feedback stays under threshold
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !(fb_below_lb_i && cycle_timer_input_i && charging))
      lb_timer <= '0;
    else if (tick && lb_timer < (period >> ccs_pkg::LB_SHIFT))
      lb_timer <= lb_timer + 1'b1;
  end

  wire lb_expired = charging && cycle_timer_input_i && fb_below_lb_i &&
                    (lb_timer >= (period >> ccs_pkg::LB_SHIFT));

  always_comb
  begin
    next_state = state;
    case (state)
      ccs_pkg::ST_OFF:
        if (lock_ok)
          next_state = ccs_pkg::ST_CC;
      ccs_pkg::ST_CC:
        if (cv_mode_i)
          next_state = (cfg.alg == ccs_pkg::ALG_TWO) ? ccs_pkg::ST_FLT : ccs_pkg::ST_ABS;
      ccs_pkg::ST_ABS:
        if (cfg.alg == ccs_pkg::ALG_LI)
        begin
          if (cycle_timer_input_i ? timer_full : current_tenth_i)
            next_state = ccs_pkg::ST_DONE;
        end
        else if (cycle_timer_input_i && timer_full)
          next_state = (cfg.alg == ccs_pkg::ALG_FOUR && !eq_done) ? ccs_pkg::ST_EQ : ccs_pkg::ST_FLT;
        else if (!cycle_timer_input_i && current_tenth_i)
          next_state = ccs_pkg::ST_FLT;
      ccs_pkg::ST_EQ:
        if (eq_hit)
          next_state = ccs_pkg::ST_FLT;
      ccs_pkg::ST_FLT:
        next_state = ccs_pkg::ST_FLT;
      ccs_pkg::ST_DONE:
        if (lb_fall || (cfg.alg == ccs_pkg::ALG_LI && fb_below_rechg_i))
          next_state = ccs_pkg::ST_CC;
      ccs_pkg::ST_LBF:
        next_state = ccs_pkg::ST_LBF;
      default:
        next_state = ccs_pkg::ST_OFF;
    endcase
    if ((cfg.alg == ccs_pkg::ALG_THREE || cfg.alg == ccs_pkg::ALG_FOUR) && lb_fall &&
        (state == ccs_pkg::ST_ABS || state == ccs_pkg::ST_EQ || state == ccs_pkg::ST_FLT))
      next_state = ccs_pkg::ST_CC;
    if (lb_expired)
      next_state = ccs_pkg::ST_LBF;
    if (!lock_ok)
      next_state = ccs_pkg::ST_OFF;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= ccs_pkg::ST_OFF;
    else
      state <= next_state;
  end

  // straps are latched once per power-on or enable cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg <= '{alg: ccs_pkg::ALG_TWO, wide: 1'b0, eq_quarter: 1'b0};
    else if (state == ccs_pkg::ST_OFF && lock_ok)
      cfg <= strap_cfg;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || state == ccs_pkg::ST_OFF)
      eq_done <= 1'b0;
    else if (next_state == ccs_pkg::ST_EQ)
      eq_done <= 1'b1;
  end

  // set wins over clear so a fresh hot flag is never lost
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      therm <= 1'b0;
    else if (over_temp_i)
      therm <= 1'b1;
    else if (cooled_i)
      therm <= 1'b0;
  end

  always_comb
  begin
    next_a_on = 1'b0;
    next_b_on = 1'b0;
    case (state)
      ccs_pkg::ST_CC,
      ccs_pkg::ST_EQ:   next_a_on = 1'b1;
      ccs_pkg::ST_ABS:
      begin
        next_a_on = 1'b1;
        next_b_on = (cfg.alg == ccs_pkg::ALG_LI);
      end
      ccs_pkg::ST_FLT:
      begin
        next_a_on = 1'b1;
        next_b_on = 1'b1;
      end
      ccs_pkg::ST_LBF:  next_b_on = 1'b1;
      default:          next_a_on = 1'b0;
    endcase
    if (therm)
    begin
      next_a_on = 1'b0;
      next_b_on = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      charge_indicator_a_oe_o <= 1'b0;
      charge_indicator_b_oe_o <= 1'b0;
    end
    else
    begin
      charge_indicator_a_oe_o <= next_a_on;
      charge_indicator_b_oe_o <= next_b_on;
    end
  end

  assign charge_indicator_a_o = 1'b0;
  assign charge_indicator_b_o = 1'b0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      charge_pump_en_o                <= 1'b0;
      switching_en_o                  <= 1'b0;
      input_isolation_gate_pulldown_o <= 1'b1;
      current_fifth_o                 <= 1'b0;
      ntc_comp_en_o                   <= 1'b0;
    end
    else
    begin
      charge_pump_en_o                <= lock_ok;
      switching_en_o                  <= lock_ok && charging && !therm && !ocp_hold && !ocp_trip_i;
      input_isolation_gate_pulldown_o <= !lock_ok;
      current_fifth_o                 <= (cycle_timer_input_i && fb_below_lb_i) || state == ccs_pkg::ST_EQ;
      ntc_comp_en_o                   <= !thermistor_disable_i;
    end
  end

  // voltage target and its offset above float per cell
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      target_o         <= ccs_pkg::TGT_FLOAT;
      target_step_mv_o <= '0;
    end
    else if (cfg.alg == ccs_pkg::ALG_LI)
    begin
      target_o         <= ccs_pkg::TGT_CHG;
      target_step_mv_o <= '0;
    end
    else if (cfg.alg != ccs_pkg::ALG_TWO && (state == ccs_pkg::ST_CC || state == ccs_pkg::ST_ABS))
    begin
      target_o         <= ccs_pkg::TGT_ABS;
      target_step_mv_o <= cfg.wide ? ccs_pkg::STEP_WIDE_ABS_MV : ccs_pkg::STEP_NORMAL_ABS_MV;
    end
    else if (state == ccs_pkg::ST_EQ)
    begin
      target_o         <= ccs_pkg::TGT_EQ;
      target_step_mv_o <= cfg.wide ? ccs_pkg::STEP_WIDE_EQ_MV : ccs_pkg::STEP_NORMAL_EQ_MV;
    end
    else
    begin
      target_o         <= ccs_pkg::TGT_FLOAT;
      target_step_mv_o <= '0;
    end
  end

  assign wide_spread_o   = cfg.wide;
  assign recharge_deep_o = cfg.wide;

  // AXI4-Lite slave, one write and one read outstanding
  assign wr_go           = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
  assign rd_go           = s_axi_arvalid_i && !s_axi_rvalid_o;
  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o  = wr_go;
  assign s_axi_arready_o = rd_go;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      period <= EOC_DEFAULT;
    else if (wr_go && s_axi_awaddr_i == ccs_pkg::REG_PERIOD)
      for (int b = 0; b < 4; b++)
        for (int i = 0; i < 8; i++)
          if (s_axi_wstrb_i[b] && (b * 8 + i) < TW)
            period[b * 8 + i] <= s_axi_wdata_i[b * 8 + i];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= ccs_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= (s_axi_awaddr_i == ccs_pkg::REG_PERIOD) ? ccs_pkg::RESP_OKAY : ccs_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= '0;
      s_axi_rresp_o  <= ccs_pkg::RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= ccs_pkg::RESP_OKAY;
      case (s_axi_araddr_i)
        ccs_pkg::REG_STATUS: s_axi_rdata_o <= {19'h0, lock_ok, eq_done, therm, cfg.wide, cfg.alg, state};
        ccs_pkg::REG_PERIOD: s_axi_rdata_o <= 32'(period);
        ccs_pkg::REG_TIMER:  s_axi_rdata_o <= 32'(cyc_timer);
        default:
        begin
          s_axi_rdata_o <= '0;
          s_axi_rresp_o <= ccs_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  a_lockout_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !lock_ok |=> input_isolation_gate_pulldown_o && !charge_pump_en_o && !switching_en_o)
    else $error("lockout did not cut gate drive");
  a_ocp_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    ocp_trip_i |=> !switching_en_o)
    else $error("switching ran after overcurrent trip");
  a_ocp_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    ocp_trip_i ##1 (!ocp_trip_i && !sw_cycle_i)[*3] |=> !switching_en_o)
    else $error("overcurrent hold ended early");
  a_therm_status: assert property (@(posedge clk_i) disable iff (rst_i)
    over_temp_i |=> therm ##1 (!charge_indicator_a_oe_o && charge_indicator_b_oe_o && !switching_en_o))
    else $error("thermal fault not shown");
  a_lb_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ccs_pkg::ST_LBF |=> !charge_indicator_a_oe_o && (charge_indicator_b_oe_o || therm) && !switching_en_o)
    else $error("low battery fault code wrong");
  a_one_equalize: assert property (@(posedge clk_i) disable iff (rst_i)
    eq_done && state != ccs_pkg::ST_EQ && lock_ok |=> state != ccs_pkg::ST_EQ)
    else $error("second equalization in one cycle");
  a_timer_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    state != ccs_pkg::ST_EQ ##1 state == ccs_pkg::ST_EQ |-> cyc_timer == '0)
    else $error("equalize timer not restarted");
  a_cv_start: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ccs_pkg::ST_CC ##1 state == ccs_pkg::ST_ABS |-> cyc_timer == '0)
    else $error("absorb timer not restarted");
  a_fifth_current: assert property (@(posedge clk_i) disable iff (rst_i)
    cycle_timer_input_i && fb_below_lb_i |=> current_fifth_o)
    else $error("one-fifth current not selected");
  a_ntc_disable: assert property (@(posedge clk_i) disable iff (rst_i)
    thermistor_disable_i |=> !ntc_comp_en_o)
    else $error("compensation left on");
  a_cfg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    state != ccs_pkg::ST_OFF |=> $stable(cfg))
    else $error("algorithm changed mid cycle");
endmodule

// ### core/ccs_pkg.sv
// Purpose: shared constants and types of the charge cycle sequencer
// Assumes: 10 MHz clk_i, synchronous active-high reset
// Notes: comparator flags arrive already synchronous to clk_i
// Functional notes
// - decode two three-level straps into algorithm and spread
// - equalize lasts quarter or eighth of period
// - two status outputs encode the charge state
// - charge target steps depend on spread
// - timer features only with timing capacitor present
// - timer starts at constant-current to constant-voltage change
// - timer restarts on entering equalization
// - low-battery timer starts when feedback below threshold
// - two-stage/lithium: low battery restarts terminated cycle (only lithium terminates; two-stage stays in float)
// - three/four-stage: low battery returns to constant current
// - capacitor and low battery select one-fifth current
// - low-battery timer expiry terminates with fault code
// - thermistor above disable level stops compensation
// - enable pump and regulator only when unlocked
// - any lockout turns off and pulls down isolation gate
// - thermal stop at hot flag, resume when cooled
// - overcurrent stops switching for four switch cycles
// - low battery beyond eighth period gives fault
// - one equalization per power-on or enable cycle
// - no capacitor: tenth current moves absorb to float
// - lithium recharge at 97.0% or 95.6% level
package ccs_pkg;
  localparam int unsigned TIMER_W          = 24;
  localparam int unsigned PRESCALE_W       = 16;
  localparam int unsigned PRESCALE_DEFAULT = 10000;
  localparam int unsigned EOC_DEFAULT      = 36000;
  localparam int unsigned EQ_SHIFT_QUARTER = 2;
  localparam int unsigned EQ_SHIFT_EIGHTH  = 3;
  localparam int unsigned LB_SHIFT         = 3;
  localparam logic [2:0]  OCP_HOLD_CYCLES  = 3'h4;
  localparam logic [8:0]  STEP_NORMAL_ABS_MV = 9'h064;
  localparam logic [8:0]  STEP_NORMAL_EQ_MV  = 9'h0E9;
  localparam logic [8:0]  STEP_WIDE_ABS_MV   = 9'h0C8;
  localparam logic [8:0]  STEP_WIDE_EQ_MV    = 9'h190;
  localparam logic [3:0]  REG_STATUS = 4'h0;
  localparam logic [3:0]  REG_PERIOD = 4'h4;
  localparam logic [3:0]  REG_TIMER  = 4'h8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {LVL_LOW = 2'h0, LVL_MID = 2'h1, LVL_HIGH = 2'h2} ccs_level_type;
  typedef enum logic [1:0] {ALG_LI = 2'h0, ALG_TWO = 2'h1, ALG_THREE = 2'h2, ALG_FOUR = 2'h3} ccs_alg_type;
  typedef enum logic [1:0] {TGT_FLOAT = 2'h0, TGT_ABS = 2'h1, TGT_EQ = 2'h2, TGT_CHG = 2'h3} ccs_target_type;
  typedef enum logic [6:0] {
    ST_OFF  = 7'h01,
    ST_CC   = 7'h02,
    ST_ABS  = 7'h04,
    ST_EQ   = 7'h08,
    ST_FLT  = 7'h10,
    ST_DONE = 7'h20,
    ST_LBF  = 7'h40
  } ccs_state_type;

  typedef struct packed {
    ccs_alg_type alg;
    logic        wide;
    logic        eq_quarter;
  } ccs_cfg_type;

  typedef struct packed {
    logic vin_ok;
    logic input_sense_supply_above_bat;
    logic input_sense_supply_near_vin;
    logic bat_ok;
    logic enable;
  } ccs_lockout_type;
endpackage

// ### core/ccs_strap_decode.sv
// Purpose: three-level strap pair to algorithm and spread
// Assumes: strap levels come from comparators, steady while sampled
// Notes: unused code 2'h3 treated as two-stage, the mildest algorithm
module ccs_strap_decode (
  input  ccs_pkg::ccs_level_type algorithm_strap_a_i,
  input  ccs_pkg::ccs_level_type algorithm_strap_b_i,
  output ccs_pkg::ccs_cfg_type   cfg_o
);
  always_comb
  begin
    cfg_o = '{alg: ccs_pkg::ALG_TWO, wide: 1'b0, eq_quarter: 1'b0};
    case ({algorithm_strap_a_i, algorithm_strap_b_i})
      {ccs_pkg::LVL_MID,  ccs_pkg::LVL_MID}:  cfg_o = '{ccs_pkg::ALG_LI, 1'b1, 1'b0};
      {ccs_pkg::LVL_HIGH, ccs_pkg::LVL_MID}:  cfg_o = '{ccs_pkg::ALG_LI, 1'b0, 1'b0};
      {ccs_pkg::LVL_MID,  ccs_pkg::LVL_LOW}:  cfg_o = '{ccs_pkg::ALG_THREE, 1'b1, 1'b0};
      {ccs_pkg::LVL_HIGH, ccs_pkg::LVL_LOW}:  cfg_o = '{ccs_pkg::ALG_THREE, 1'b0, 1'b0};
      {ccs_pkg::LVL_LOW,  ccs_pkg::LVL_HIGH}: cfg_o = '{ccs_pkg::ALG_FOUR, 1'b0, 1'b1};
      {ccs_pkg::LVL_HIGH, ccs_pkg::LVL_HIGH}: cfg_o = '{ccs_pkg::ALG_FOUR, 1'b0, 1'b0};
      {ccs_pkg::LVL_MID,  ccs_pkg::LVL_HIGH}: cfg_o = '{ccs_pkg::ALG_FOUR, 1'b1, 1'b0};
      default:                                cfg_o = '{ccs_pkg::ALG_TWO, 1'b0, 1'b0};
    endcase
  end
endmodule

// ### core/ccs_hold_counter.sv
// Purpose: down counter that holds a busy level for a number of events
// Assumes: dec_i is a one-cycle pulse per counted event
// Notes: load wins over decrement
module ccs_hold_counter #(
  parameter int unsigned W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic         dec_i,
  output logic              busy_o
);
  logic [W-1:0] count;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count <= '0;
    else if (load_i)
      count <= load_val_i;
    else if (dec_i && count != '0)
      count <= count - 1'b1;
  end

  assign busy_o = (count != '0);
endmodule

// ### tb/ccs_stage_model.sv
// Purpose: power stage, loop and oscillator seen by the sequencer
// Assumes: loop regulates voltage a few clocks after switching starts
// Notes: battery_full_i and taper_i stand in for the battery
module ccs_stage_model (
  input  wire logic clk_i,
  input  wire logic battery_full_i,
  input  wire logic taper_i,
  input  wire logic switching_en_i,
  output logic      sw_cycle_o = 1'b0,
  output logic      cv_mode_o = 1'b0,
  output logic      current_tenth_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] osc = 3'h0;
  logic [2:0] settle = 3'h0;
  // oscillator runs free, sync input held low: hold-off counts must not depend on switching
  always @(posedge clk_i)
  begin
    osc <= (osc == 3'h4) ? 3'h0 : osc + 3'h1;
    sw_cycle_o <= (osc == 3'h4);
    settle <= {settle[1:0], battery_full_i & switching_en_i};
    cv_mode_o <= settle[2];
    current_tenth_o <= taper_i & settle[2];
  end
endmodule

// ### tb/testbench.sv
// Purpose: self-checking bench of the charge sequencer
// Assumes: PRESCALE of 2 and a period of 16 ticks keep timers short
// Notes: read answers are checked from a queue of expectations
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, full = 1'b0, taper = 1'b0;
  ccs_pkg::ccs_level_type algorithm_strap_a_i = ccs_pkg::LVL_LOW, algorithm_strap_b_i = ccs_pkg::LVL_LOW;
  ccs_pkg::ccs_lockout_type supply_lockout_i = 5'h1F;
  logic cycle_timer_input_i = 1'b0, fb_below_lb_i = 1'b0, fb_below_rechg_i = 1'b0, thermistor_disable_i = 1'b0;
  logic over_temp_i = 1'b0, cooled_i = 1'b0, ocp_trip_i = 1'b0, s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0, s_axi_wstrb_i = 4'hF;
  logic [31:0] s_axi_wdata_i = 32'h0, lf = 32'h764B, s_axi_rdata_o;
  logic sw_cycle_i, cv_mode_i, current_tenth_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o, charge_indicator_a_oe_o, charge_indicator_b_oe_o, charge_pump_en_o;
  logic switching_en_o, input_isolation_gate_pulldown_o, current_fifth_o, ntc_comp_en_o;
  logic wide_spread_o, recharge_deep_o, charge_indicator_a_o, charge_indicator_b_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic [8:0] target_step_mv_o;
  ccs_pkg::ccs_target_type target_o;
  // {wide, algorithm} per strap pair, index a*3+b
  logic [2:0] dec [9] = '{3'h1, 3'h1, 3'h3, 3'h6, 3'h4, 3'h7, 3'h2, 3'h0, 3'h3};
  logic [65:0] q [$];
  logic [65:0] ent;
  int failures = 0;
  int num_checks = 0;

  always #50 clk_i = ~clk_i;

  ccs_charge_sequencer #(.PRESCALE(2)) i_dut (.clk_i, .rst_i, .algorithm_strap_a_i, .algorithm_strap_b_i,
    .supply_lockout_i, .cycle_timer_input_i, .cv_mode_i, .current_tenth_i, .fb_below_lb_i, .fb_below_rechg_i,
    .thermistor_disable_i, .over_temp_i, .cooled_i, .ocp_trip_i, .sw_cycle_i, .charge_indicator_a_o,
    .charge_indicator_a_oe_o, .charge_indicator_b_o, .charge_indicator_b_oe_o, .charge_pump_en_o,
    .switching_en_o, .input_isolation_gate_pulldown_o, .target_o, .target_step_mv_o, .wide_spread_o,
    .recharge_deep_o, .current_fifth_o, .ntc_comp_en_o, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i,
    .s_axi_rdata_o, .s_axi_rresp_o);

  ccs_stage_model i_stage (.clk_i, .battery_full_i(full), .taper_i(taper), .switching_en_i(switching_en_o),
    .sw_cycle_o(sw_cycle_i), .cv_mode_o(cv_mode_i), .current_tenth_o(current_tenth_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d, failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do @(posedge clk_i); while (s_axi_awready_o !== 1'b1 || s_axi_wready_o !== 1'b1);
    s_axi_awvalid_i <= 1'b0;
    s_axi_wvalid_i <= 1'b0;
    do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    check(s_axi_bresp_o, e);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
    q.push_back({r, m, e});
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
  endtask

  // straps are only taken on leaving lockout, so each setting needs a cycle
  task automatic restart(input int a, input int b);
    supply_lockout_i.enable <= 1'b0;
    cyc(2);
    check(input_isolation_gate_pulldown_o, 1'b1);
    check(switching_en_o, 1'b0);
    algorithm_strap_a_i <= ccs_pkg::ccs_level_type'(a);
    algorithm_strap_b_i <= ccs_pkg::ccs_level_type'(b);
    supply_lockout_i.enable <= 1'b1;
    cyc(3);
    check(charge_pump_en_o, 1'b1);
  endtask

  always @(posedge clk_i)
    if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i === 1'b1)
    begin
      ent = q.pop_front();
      check(s_axi_rdata_o & ent[63:32], ent[31:0]);
      check(s_axi_rresp_o, ent[65:64]);
    end

  initial
  begin
    #(6000 * 100);
    failures++;
    give_verdict();
  end

  initial
  begin
    repeat (3) @(posedge clk_i);
    check(input_isolation_gate_pulldown_o, 1'b1);
    rst_i <= 1'b0;
    repeat (3)
    begin
      lf = lfsr(lf);
      wr(ccs_pkg::REG_PERIOD, lf, ccs_pkg::RESP_OKAY);
      rd(ccs_pkg::REG_PERIOD, 32'h00FFFFFF, lf & 32'h00FFFFFF, ccs_pkg::RESP_OKAY);
    end
    wr(ccs_pkg::REG_PERIOD, 32'h10, ccs_pkg::RESP_OKAY);
    wr(ccs_pkg::REG_STATUS, 32'h0, ccs_pkg::RESP_SLVERR);
    rd(4'hC, 32'hFFFFFFFF, 32'h0, ccs_pkg::RESP_SLVERR);
    for (int i = 0; i < 9; i++)
    begin
      restart(i / 3, i % 3);
      rd(ccs_pkg::REG_STATUS, 32'h380, 32'(dec[i]) << 7, ccs_pkg::RESP_OKAY);
      check({charge_indicator_a_oe_o, charge_indicator_b_oe_o}, 2'h2);
    end
    restart(2, 0);
    full <= 1'b1;
    cyc(8);
    rd(ccs_pkg::REG_STATUS, 32'h7F, 32'h4, ccs_pkg::RESP_OKAY);
    check(target_o, ccs_pkg::TGT_ABS);
    check(target_step_mv_o, 9'h064);
    taper <= 1'b1;
    cyc(4);
    check({target_o, charge_indicator_a_oe_o, charge_indicator_b_oe_o}, {ccs_pkg::TGT_FLOAT, 2'h3});
    full <= 1'b0;
    taper <= 1'b0;
    fb_below_lb_i <= 1'b1;
    cyc(6);
    check({target_o, charge_indicator_a_oe_o, charge_indicator_b_oe_o}, {ccs_pkg::TGT_ABS, 2'h2});
    fb_below_lb_i <= 1'b0;
    over_temp_i <= 1'b1;
    thermistor_disable_i <= 1'b1;
    cyc(4);
    check({switching_en_o, charge_indicator_a_oe_o, charge_indicator_b_oe_o}, 3'h1);
    check(ntc_comp_en_o, 1'b0);
    over_temp_i <= 1'b0;
    thermistor_disable_i <= 1'b0;
    cyc(4);
    check(switching_en_o, 1'b0);
    cooled_i <= 1'b1;
    cyc(4);
    check(switching_en_o, 1'b1);
    cooled_i <= 1'b0;
    ocp_trip_i <= 1'b1;
    cyc(2);
    ocp_trip_i <= 1'b0;
    cyc(10);
    check(switching_en_o, 1'b0);
    cyc(20);
    check(switching_en_o, 1'b1);
    cycle_timer_input_i <= 1'b1;
    restart(0, 0);
    fb_below_lb_i <= 1'b1;
    cyc(2);
    check({current_fifth_o, charge_indicator_b_oe_o}, 2'h2);
    cyc(20);
    check({charge_indicator_a_oe_o, charge_indicator_b_oe_o}, 2'h1);
    fb_below_lb_i <= 1'b0;
    restart(0, 2);
    full <= 1'b1;
    while (target_o !== ccs_pkg::TGT_EQ) @(posedge clk_i);
    check({current_fifth_o, target_step_mv_o}, {1'b1, 9'h0E9});
    cyc(6);
    check(target_o, ccs_pkg::TGT_EQ);
    cyc(6);
    check(target_o, ccs_pkg::TGT_FLOAT);
    cycle_timer_input_i <= 1'b0;
    taper <= 1'b1;
    restart(1, 1);
    cyc(12);
    check({charge_indicator_a_oe_o, charge_indicator_b_oe_o}, 2'h0);
    check({charge_indicator_a_o, charge_indicator_b_o}, 2'h0);
    check({wide_spread_o, recharge_deep_o}, 2'h3);
    fb_below_rechg_i <= 1'b1;
    cyc(3);
    check(charge_indicator_a_oe_o, 1'b1);
    give_verdict();
  end
endmodule
